// >>> rf4_regs.sv
// Purpose: control, on and sleep registers of regulator four with its enable state
// Assumes: hardware-control, hardware-enable and timeslot inputs share clk;
//          the undervoltage comparator is asynchronous
// Notes:   outputs are registered one cycle after the state that drives them
// Notes on behaviour
// - undervoltage action: ignore, shut regulator, reset device
// - every undervoltage event raises an interrupt
// - source field selects hardware control inputs
// - hardware control voltage picks on or sleep code
// - hardware mode: low power, off, or on mode
// - float bit chooses discharge; switch bit pass mode
// - low power level bit selects 50 or 20mA
// - on slot 1 to 5 enables in timeslot
// - on slot 6, 7 follow hardware enables
// - on mode bit picks normal or low power
// - voltage code maps 0.9V to 3.3V
// - on register resets to all zero
// - sleep voltage uses same mapping as on
// - under hardware enable, sleep slot picks timeslot
`timescale 1ns/1ps
module rf4_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        hw_control_1,
  input  wire logic        hw_control_2,
  input  wire logic        hw_enable_1,
  input  wire logic        hw_enable_2,
  input  wire logic [2:0]  seq_slot,
  input  wire logic        seq_on_step,
  input  wire logic        seq_sleep_step,
  input  wire logic        uv_detect,
  output logic             reg_enable,
  output logic             reg_low_power,
  output logic             low_power_level,
  output logic             discharge_on,
  output logic             pass_switch_mode,
  output logic      [4:0]  vout_code,
  output logic      [11:0] vout_mv,
  output logic             uv_irq,
  output logic             device_reset_req
);

  function automatic logic [11:0] code_to_mv(input logic [4:0] c);
    logic [11:0] k;
    k = {7'h00, c};
    if (c <= rf4_pkg::VCODE_KNEE) begin
      code_to_mv = 12'(rf4_pkg::V_BASE_MV + k * rf4_pkg::V_FINE_MV);
    end else begin
      code_to_mv = 12'(rf4_pkg::V_HIGH_MV + (k - 12'h00f) * rf4_pkg::V_COARSE_MV);
    end
  endfunction : code_to_mv

  typedef struct packed {
    logic [15:0]         ctl;
    logic [15:0]         on;
    logic [15:0]         slp;
    rf4_pkg::rf4_state_t st;
    logic                sleep_pend;
    logic [2:0]          uv_q;
    logic                uv_lvl;
    logic [15:0]         rdata;
    logic                en;
    logic                lp;
    logic                lvl;
    logic                dis;
    logic                sw;
    logic [4:0]          vcode;
    logic [11:0]         mv;
    logic                irq;
    logic                rst_req;
  } rf4_regs_t;

  rf4_regs_t s_r;
  rf4_regs_t s_nxt;

  logic [1:0] uv_act;
  logic [1:0] hwc_src;
  logic [1:0] hwc_mode;
  logic [2:0] on_slot;
  logic [2:0] slp_slot;
  logic       hwc_act;
  logic       hwen_mode;
  logic       hwen_lvl;
  logic [2:0] off_slot;
  logic       uv_event;
  logic       run;
  logic       mode_lp;
  logic [4:0] code;

  assign uv_act   = s_r.ctl[rf4_pkg::UV_ACT_LSB +: 2];
  assign hwc_src  = s_r.ctl[rf4_pkg::HWC_SRC_LSB +: 2];
  assign hwc_mode = s_r.ctl[rf4_pkg::HWC_MODE_LSB +: 2];
  assign on_slot  = s_r.on[rf4_pkg::SLOT_LSB +: 3];
  assign slp_slot = s_r.slp[rf4_pkg::SLOT_LSB +: 3];

  always_comb begin
    s_nxt = s_r;
    // source decode for hardware control
    case (hwc_src)
      rf4_pkg::HWC_IN1:    hwc_act = hw_control_1;
      rf4_pkg::HWC_IN2:    hwc_act = hw_control_2;
      rf4_pkg::HWC_EITHER: hwc_act = hw_control_1 | hw_control_2;
      default:             hwc_act = 1'b0;
    endcase
    hwen_mode = (on_slot == rf4_pkg::SLOT_HWEN1) || (on_slot == rf4_pkg::SLOT_HWEN2);
    hwen_lvl  = (on_slot == rf4_pkg::SLOT_HWEN1) ? hw_enable_1 : hw_enable_2;
    // sleep slot 1..5 counts down from timeslot 5
    if (slp_slot == rf4_pkg::SLOT_NEVER) begin
      off_slot = rf4_pkg::SLOT_LAST;
    end else if (slp_slot == rf4_pkg::SLOT_HWEN1) begin
      off_slot = rf4_pkg::SLOT_MID;
    end else if (slp_slot == rf4_pkg::SLOT_HWEN2) begin
      off_slot = rf4_pkg::SLOT_FIRST;
    end else begin
      off_slot = 3'(rf4_pkg::SLOT_COUNT - slp_slot);
    end

    // undervoltage comparator: change counts once stages two and three agree
    s_nxt.uv_q = {s_r.uv_q[1:0], uv_detect};
    if (s_r.uv_q[1] == s_r.uv_q[2]) begin
      s_nxt.uv_lvl = s_r.uv_q[2];
    end
    uv_event = s_nxt.uv_lvl & ~s_r.uv_lvl;

    // register writes
    if (wr) begin
      case (addr)
        rf4_pkg::ADDR_CTL:   s_nxt.ctl = wdata & rf4_pkg::MASK_CTL;
        rf4_pkg::ADDR_ON:    s_nxt.on  = wdata & rf4_pkg::MASK_ON;
        rf4_pkg::ADDR_SLEEP: s_nxt.slp = wdata & rf4_pkg::MASK_SLEEP;
        default:             s_nxt.ctl = s_r.ctl;
      endcase
    end

    // enable sequencing
    case (s_r.st)
      rf4_pkg::RF4_OFF: begin
        if (hwen_mode) begin
          if (hwen_lvl) begin
            s_nxt.st = rf4_pkg::RF4_ON;
          end
        end else if (seq_on_step && on_slot != rf4_pkg::SLOT_NEVER
                     && seq_slot == on_slot) begin
          s_nxt.st = rf4_pkg::RF4_ON;
        end
      end
      rf4_pkg::RF4_ON: begin
        if (hwen_mode) begin
          if (!hwen_lvl) begin
            if (slp_slot != rf4_pkg::SLOT_NEVER && slp_slot <= rf4_pkg::SLOT_LAST) begin
              s_nxt.sleep_pend = 1'b1;
            end else begin
              s_nxt.st = rf4_pkg::RF4_OFF;
            end
          end else begin
            s_nxt.sleep_pend = 1'b0;
          end
          if (s_r.sleep_pend && seq_sleep_step && seq_slot == off_slot) begin
            s_nxt.st         = rf4_pkg::RF4_SLEEP;
            s_nxt.sleep_pend = 1'b0;
          end
        end else if (seq_sleep_step && seq_slot == off_slot) begin
          if (slp_slot != rf4_pkg::SLOT_NEVER && slp_slot <= rf4_pkg::SLOT_LAST) begin
            s_nxt.st = rf4_pkg::RF4_OFF;
          end else begin
            s_nxt.st = rf4_pkg::RF4_SLEEP;
          end
        end
      end
      rf4_pkg::RF4_SLEEP: begin
        if (hwen_mode ? hwen_lvl
                      : (seq_on_step && seq_slot == on_slot)) begin
          s_nxt.st = rf4_pkg::RF4_ON;
        end
      end
      default: s_nxt.st = rf4_pkg::RF4_OFF;
    endcase
    if (!hwen_mode) begin
      s_nxt.sleep_pend = 1'b0;
    end

    // undervoltage shutdown beats any enable in the same cycle
    if (uv_event && uv_act == rf4_pkg::UV_SHUTDOWN) begin
      s_nxt.st         = rf4_pkg::RF4_OFF;
      s_nxt.sleep_pend = 1'b0;
    end
    s_nxt.irq     = uv_event;
    s_nxt.rst_req = uv_event && (uv_act == rf4_pkg::UV_SYSRESET);

    // operating point from the current state
    run     = (s_r.st != rf4_pkg::RF4_OFF);
    mode_lp = s_r.on[rf4_pkg::OPMODE_BIT];
    code    = s_r.on[rf4_pkg::VCODE_LSB +: 5];
    if (s_r.st == rf4_pkg::RF4_SLEEP) begin
      mode_lp = s_r.slp[rf4_pkg::OPMODE_BIT];
      code    = s_r.slp[rf4_pkg::VCODE_LSB +: 5];
    end
    if (run && hwc_act) begin
      code = s_r.ctl[rf4_pkg::HWC_VPICK] ? s_r.slp[rf4_pkg::VCODE_LSB +: 5]
                                          : s_r.on[rf4_pkg::VCODE_LSB +: 5];
      case (hwc_mode)
        rf4_pkg::HMODE_OFF: run     = 1'b0;
        rf4_pkg::HMODE_ON:  mode_lp = s_r.on[rf4_pkg::OPMODE_BIT];
        default:            mode_lp = 1'b1;
      endcase
    end
    s_nxt.en    = run;
    s_nxt.lp    = run & mode_lp;
    s_nxt.lvl   = s_r.ctl[rf4_pkg::LP_LEVEL_BIT];
    s_nxt.dis   = ~run & ~s_r.ctl[rf4_pkg::FLOAT_BIT];
    s_nxt.sw    = s_r.ctl[rf4_pkg::SWITCH_BIT];
    s_nxt.vcode = code;
    s_nxt.mv    = code_to_mv(code);

    // read data stand only in the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        rf4_pkg::ADDR_CTL:    s_nxt.rdata = s_r.ctl;
        rf4_pkg::ADDR_ON:     s_nxt.rdata = s_r.on;
        rf4_pkg::ADDR_SLEEP:  s_nxt.rdata = s_r.slp;
        rf4_pkg::ADDR_STATUS: begin
          s_nxt.rdata[rf4_pkg::ST_STATE_LSB +: 2] = s_r.st;
          s_nxt.rdata[rf4_pkg::ST_HWC_BIT]        = hwc_act;
          s_nxt.rdata[rf4_pkg::ST_UV_BIT]         = s_r.uv_lvl;
          s_nxt.rdata[rf4_pkg::ST_VCODE_LSB +: 5] = s_r.vcode;
        end
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.ctl   <= rf4_pkg::RST_CTL;
      s_r.on    <= rf4_pkg::RST_ON;
      s_r.slp   <= rf4_pkg::RST_SLEEP;
      s_r.st    <= rf4_pkg::RF4_OFF;
      s_r.dis   <= 1'b1;
      s_r.mv    <= rf4_pkg::V_BASE_MV;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata            = s_r.rdata;
  assign reg_enable       = s_r.en;
  assign reg_low_power    = s_r.lp;
  assign low_power_level  = s_r.lvl;
  assign discharge_on     = s_r.dis;
  assign pass_switch_mode = s_r.sw;
  assign vout_code        = s_r.vcode;
  assign vout_mv          = s_r.mv;
  assign uv_irq           = s_r.irq;
  assign device_reset_req = s_r.rst_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_uv_rise;
    s_r.uv_lvl == 1'b0 ##1 s_r.uv_lvl == 1'b1;
  endsequence

  // level and interrupt register on the same edge
  property p_uv_irq;
    s_uv_rise |-> uv_irq;
  endproperty
  a_uv_irq: assert property (p_uv_irq)
    else $error("undervoltage gave no interrupt");

  property p_irq_only_uv;
    uv_irq |-> s_r.uv_lvl && !$past(s_r.uv_lvl);
  endproperty
  a_irq_only_uv: assert property (p_irq_only_uv)
    else $error("interrupt without undervoltage");

  property p_uv_reset;
    s_uv_rise ##0 ($past(uv_act) == rf4_pkg::UV_SYSRESET) |-> device_reset_req;
  endproperty
  a_uv_reset: assert property (p_uv_reset)
    else $error("device reset not requested");

  property p_uv_shut;
    s_uv_rise ##0 ($past(uv_act) == rf4_pkg::UV_SHUTDOWN) |-> s_r.st == rf4_pkg::RF4_OFF;
  endproperty
  a_uv_shut: assert property (p_uv_shut)
    else $error("regulator not shut on undervoltage");

  property p_reset_only_uv;
    device_reset_req |-> $past(uv_act) == rf4_pkg::UV_SYSRESET && uv_irq;
  endproperty
  a_reset_only_uv: assert property (p_reset_only_uv)
    else $error("spurious device reset");

  property p_slot_enable;
    s_r.st == rf4_pkg::RF4_OFF && !hwen_mode && on_slot != rf4_pkg::SLOT_NEVER
      && seq_on_step && seq_slot == on_slot && !uv_event
      |=> s_r.st == rf4_pkg::RF4_ON;
  endproperty
  a_slot_enable: assert property (p_slot_enable)
    else $error("timeslot did not enable");

  property p_never_slot;
    on_slot == rf4_pkg::SLOT_NEVER && s_r.st == rf4_pkg::RF4_OFF |=> s_r.st != rf4_pkg::RF4_ON;
  endproperty
  a_never_slot: assert property (p_never_slot)
    else $error("slot 000 enabled regulator");

  property p_hwen_follow;
    s_r.st == rf4_pkg::RF4_OFF && hwen_mode && hwen_lvl && !uv_event
      |=> s_r.st == rf4_pkg::RF4_ON ##1 reg_enable || hwc_act;
  endproperty
  a_hwen_follow: assert property (p_hwen_follow)
    else $error("hardware enable ignored");

  property p_hwc_off;
    s_r.st != rf4_pkg::RF4_OFF && hwc_act && hwc_mode == rf4_pkg::HMODE_OFF
      |=> !reg_enable && discharge_on == !$past(s_r.ctl[rf4_pkg::FLOAT_BIT]);
  endproperty
  a_hwc_off: assert property (p_hwc_off)
    else $error("hardware control off not applied");

  property p_hwc_vpick;
    s_r.st != rf4_pkg::RF4_OFF && hwc_act && s_r.ctl[rf4_pkg::HWC_VPICK]
      |=> vout_code == $past(s_r.slp[4:0]);
  endproperty
  a_hwc_vpick: assert property (p_hwc_vpick)
    else $error("wrong hardware control voltage");

  property p_on_mode;
    s_r.st == rf4_pkg::RF4_ON && !hwc_act |=> reg_low_power == $past(s_r.on[8]);
  endproperty
  a_on_mode: assert property (p_on_mode)
    else $error("on operating mode not applied");

  property p_vmap;
    vout_code == 5'h0f |-> vout_mv == 12'd1700;
  endproperty
  a_vmap: assert property (p_vmap)
    else $error("voltage mapping wrong at knee");

  property p_read_once;
    rd && addr == rf4_pkg::ADDR_ON ##1 !rd |-> rdata == $past(s_r.on) ##1 rdata == 16'h0000;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data did not stand one cycle");

endmodule : rf4_regs

// >>> rf4_pkg.sv
// Purpose: constants for the regulator-four control register bank
// Assumes: 16-bit register words on a plain strobe port
// Notes:   field positions, reset words and voltage mapping
package rf4_pkg;
  // register addresses
  localparam logic [15:0] ADDR_CTL    = 16'h4071;
  localparam logic [15:0] ADDR_ON     = 16'h4072;
  localparam logic [15:0] ADDR_SLEEP  = 16'h4073;
  localparam logic [15:0] ADDR_STATUS = 16'h4080;
  // writable bit masks, reserved bits read as zero
  localparam logic [15:0] MASK_CTL    = 16'hdfc1;
  localparam logic [15:0] MASK_ON     = 16'he11f;
  localparam logic [15:0] MASK_SLEEP  = 16'he11f;
  // reset words
  localparam logic [15:0] RST_CTL     = 16'h0200;
  localparam logic [15:0] RST_ON      = 16'h0000;
  localparam logic [15:0] RST_SLEEP   = 16'h0100;
  // control register fields
  localparam int UV_ACT_LSB  = 14;
  localparam int HWC_SRC_LSB = 11;
  localparam int HWC_VPICK   = 10;
  localparam int HWC_MODE_LSB = 8;
  localparam int FLOAT_BIT   = 7;
  localparam int SWITCH_BIT  = 6;
  localparam int LP_LEVEL_BIT = 0;
  // on and sleep register fields
  localparam int SLOT_LSB    = 13;
  localparam int OPMODE_BIT  = 8;
  localparam int VCODE_LSB   = 0;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_HWC_BIT   = 2;
  localparam int ST_UV_BIT    = 3;
  localparam int ST_VCODE_LSB = 4;
  // codes
  localparam logic [1:0] UV_IGNORE   = 2'h0;
  localparam logic [1:0] UV_SHUTDOWN = 2'h1;
  localparam logic [1:0] UV_SYSRESET = 2'h2;
  localparam logic [1:0] HWC_OFF     = 2'h0;
  localparam logic [1:0] HWC_IN1     = 2'h1;
  localparam logic [1:0] HWC_IN2     = 2'h2;
  localparam logic [1:0] HWC_EITHER  = 2'h3;
  localparam logic [1:0] HMODE_OFF   = 2'h1;
  localparam logic [1:0] HMODE_ON    = 2'h3;
  localparam logic [2:0] SLOT_NEVER  = 3'h0;
  localparam logic [2:0] SLOT_LAST   = 3'h5;
  localparam logic [2:0] SLOT_HWEN1  = 3'h6;
  localparam logic [2:0] SLOT_HWEN2  = 3'h7;
  localparam logic [2:0] SLOT_COUNT  = 3'h6;
  localparam logic [2:0] SLOT_MID    = 3'h3;
  localparam logic [2:0] SLOT_FIRST  = 3'h1;
  // voltage mapping in millivolts
  localparam logic [4:0]  VCODE_KNEE   = 5'h0e;
  localparam logic [11:0] V_BASE_MV    = 12'd900;
  localparam logic [11:0] V_FINE_MV    = 12'd50;
  localparam logic [11:0] V_HIGH_MV    = 12'd1700;
  localparam logic [11:0] V_COARSE_MV  = 12'd100;
  typedef enum logic [1:0] {RF4_OFF, RF4_ON, RF4_SLEEP} rf4_state_t;
endpackage : rf4_pkg

// >>> test_regulator_four_control_regs.sv
// Purpose: self-checking bench for the regulator-four register bank
// Assumes: bench drives every port itself; outputs settle two edges after a cause
// Notes:   expectations come from a small integer model of the voltage map
`timescale 1ns/1ps
module test_regulator_four_control_regs;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        hw_control_1 = 1'b0;
  logic        hw_control_2 = 1'b0;
  logic        hw_enable_1 = 1'b0;
  logic        hw_enable_2 = 1'b0;
  logic [2:0]  seq_slot = 3'h0;
  logic        seq_on_step = 1'b0;
  logic        seq_sleep_step = 1'b0;
  logic        uv_detect = 1'b0;
  logic        reg_enable, reg_low_power, low_power_level, discharge_on, pass_switch_mode;
  logic [4:0]  vout_code;
  logic [11:0] vout_mv;
  logic        uv_irq, device_reset_req;
  int          err_total = 0;
  int          checked = 0;
  int          irq_cnt = 0;
  int          rst_cnt = 0;
  int          seed = 32'h407dfd68;
  int          i0, r0;
  int          mdl_q[$];
  logic [15:0] d, a;
  logic [4:0]  v;

  rf4_regs u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hw_control_1(hw_control_1), .hw_control_2(hw_control_2),
    .hw_enable_1(hw_enable_1), .hw_enable_2(hw_enable_2), .seq_slot(seq_slot),
    .seq_on_step(seq_on_step), .seq_sleep_step(seq_sleep_step), .uv_detect(uv_detect),
    .reg_enable(reg_enable), .reg_low_power(reg_low_power),
    .low_power_level(low_power_level), .discharge_on(discharge_on),
    .pass_switch_mode(pass_switch_mode), .vout_code(vout_code), .vout_mv(vout_mv),
    .uv_irq(uv_irq), .device_reset_req(device_reset_req));

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (uv_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (device_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  task stop_test;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task wr_reg(input logic [15:0] ad, input logic [15:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [15:0] ad, input logic [15:0] e);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask : rd_chk

  task step(input logic on, input logic [2:0] s);
    @(posedge clk);
    seq_slot <= s;
    seq_on_step <= on;
    seq_sleep_step <= !on;
    @(posedge clk);
    seq_on_step <= 1'b0;
    seq_sleep_step <= 1'b0;
    cyc(3);
  endtask : step

  function automatic int exp_mv(input int c);
    return (c <= 14) ? 900 + 50 * c : 1700 + 100 * (c - 15);
  endfunction : exp_mv

  task done(input string n);
    $display("test %s done", n);
  endtask : done

  task uv_event(input logic [1:0] act);
    wr_reg(rf4_pkg::ADDR_CTL, {act, 14'h0000} | ((act == 2'h1) ? 16'h00c1 : 16'h0000));
    cyc(2);
    i0 = irq_cnt;
    r0 = rst_cnt;
    uv_detect <= 1'b1;
    cyc(10);
    uv_detect <= 1'b0;
    cyc(8);
    chk("uv_irq count", 16'(irq_cnt - i0), 16'h0001);
    chk("reset count", 16'(rst_cnt - r0), {15'h0, act == 2'h2});
    chk("enable after uv", reg_enable, {15'h0, act != 2'h1});
    chk("discharge", discharge_on, 16'h0000);
    chk("switch copy", pass_switch_mode, {15'h0, act == 2'h1});
    chk("lp level copy", low_power_level, {15'h0, act == 2'h1});
  endtask : uv_event

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test;
  end

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    rd_chk(rf4_pkg::ADDR_CTL, rf4_pkg::RST_CTL);
    rd_chk(rf4_pkg::ADDR_ON, rf4_pkg::RST_ON);
    rd_chk(rf4_pkg::ADDR_SLEEP, rf4_pkg::RST_SLEEP);
    chk("reset enable", reg_enable, 16'h0000);
    chk("reset mv", vout_mv, 16'd900);
    done("reset");
    for (int i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      a = rf4_pkg::ADDR_CTL + 16'(i % 3);
      wr_reg(a, d);
      mdl_q.push_back(int'(d & ((i % 3 == 0) ? rf4_pkg::MASK_CTL : rf4_pkg::MASK_ON)));
      rd_chk(a, 16'(mdl_q.pop_front()));
    end
    wr_reg(16'h4075, 16'hffff);
    rd_chk(16'h4075, 16'h0000);
    wr_reg(rf4_pkg::ADDR_CTL, 16'h0000);
    wr_reg(rf4_pkg::ADDR_SLEEP, 16'h2000);
    done("registers");
    for (int k = 0; k < 6; k++) begin
      v = 5'($random(seed));
      wr_reg(rf4_pkg::ADDR_ON, {3'(k), 4'h0, 1'(k), 3'h0, v});
      step(1'b1, (k == 0) ? 3'h1 : 3'(k));
      chk("slot enable", reg_enable, {15'h0, k != 0});
      if (k != 0) begin
        chk("slot vcode", vout_code, 16'(v));
        chk("on mode", reg_low_power, 16'(k % 2));
        chk("no discharge on", discharge_on, 16'h0000);
      end
      step(1'b0, 3'h5);
      chk("sleep slot off", reg_enable, 16'h0000);
      chk("discharge off", discharge_on, 16'h0001);
    end
    done("sequencer");
    wr_reg(rf4_pkg::ADDR_ON, 16'h2000);
    step(1'b1, 3'h1);
    for (int c = 0; c < 32; c++) begin
      wr_reg(rf4_pkg::ADDR_ON, 16'h2000 | 16'(c));
      cyc(3);
      chk("vout_mv", vout_mv, 16'(exp_mv(c)));
    end
    done("voltage map");
    wr_reg(rf4_pkg::ADDR_ON, 16'h2005);
    wr_reg(rf4_pkg::ADDR_SLEEP, 16'h011f);
    wr_reg(rf4_pkg::ADDR_CTL, 16'h0f00);
    hw_control_1 <= 1'b1;
    cyc(4);
    chk("hwc sleep code", vout_code, 16'h001f);
    chk("hwc on mode", reg_low_power, 16'h0000);
    hw_control_1 <= 1'b0;
    hw_control_2 <= 1'b1;
    cyc(4);
    chk("wrong source", vout_code, 16'h0005);
    wr_reg(rf4_pkg::ADDR_CTL, 16'h1f00);
    cyc(3);
    chk("either source", vout_code, 16'h001f);
    wr_reg(rf4_pkg::ADDR_CTL, 16'h1d00);
    cyc(3);
    chk("hwc off mode", reg_enable, 16'h0000);
    wr_reg(rf4_pkg::ADDR_CTL, 16'h1c00);
    cyc(3);
    chk("hwc low power", reg_low_power, 16'h0001);
    hw_control_2 <= 1'b0;
    cyc(4);
    chk("release enable", reg_enable, 16'h0001);
    chk("release vcode", vout_code, 16'h0005);
    done("hardware control");
    uv_event(2'h0);
    uv_event(2'h2);
    uv_event(2'h1);
    done("undervoltage");
    wr_reg(rf4_pkg::ADDR_CTL, 16'h0000);
    wr_reg(rf4_pkg::ADDR_SLEEP, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      wr_reg(rf4_pkg::ADDR_ON, (j == 0) ? 16'hc00a : 16'he00a);
      hw_enable_1 <= (j == 1);
      hw_enable_2 <= (j == 0);
      cyc(4);
      chk("other enable", reg_enable, 16'h0000);
      hw_enable_1 <= (j == 0);
      hw_enable_2 <= (j == 1);
      cyc(4);
      chk("hw enable on", reg_enable, 16'h0001);
      hw_enable_1 <= 1'b0;
      hw_enable_2 <= 1'b0;
      cyc(4);
      chk("hw enable off", reg_enable, 16'h0000);
    end
    wr_reg(rf4_pkg::ADDR_ON, 16'hc00a);
    wr_reg(rf4_pkg::ADDR_SLEEP, 16'h411f);
    hw_enable_1 <= 1'b1;
    cyc(4);
    hw_enable_1 <= 1'b0;
    cyc(4);
    chk("pending on", reg_enable, 16'h0001);
    step(1'b0, 3'h4);
    chk("sleep vcode", vout_code, 16'h001f);
    chk("sleep mode", reg_low_power, 16'h0001);
    done("hardware enable");
    wr_reg(rf4_pkg::ADDR_ON, 16'h2003);
    wr_reg(rf4_pkg::ADDR_SLEEP, 16'hc01f);
    step(1'b1, 3'h1);
    chk("wake vcode", vout_code, 16'h0003);
    step(1'b0, 3'h3);
    chk("slot6 enable", reg_enable, 16'h0001);
    chk("slot6 vcode", vout_code, 16'h001f);
    chk("slot6 mv", vout_mv, 16'(exp_mv(31)));
    chk("slot6 mode", reg_low_power, 16'h0000);
    done("sleep slots");
    stop_test;
  end
endmodule : test_regulator_four_control_regs
